//--- inc/lgs_pkg.sv
// package of constants and types for the led gradation sequencer
// Function
// - each group's sequence runs through 64 consecutive grid steps
// - each of 24 channels belongs to exactly one of four groups
// - channel group field in bits 2:1, enable in bit 0, both reset zero
// - each channel holds three independent 6-bit current presets
// - grid holds 2-bit selector per group: 00 off, 01/10/11 preset 1/2/3
// - disabled channel stays off whatever the grid selects
// - two configuration sides; only the execute side drives the outputs
// - sequence starts when output enable low and run enable set
// - sequence begins at grid 0; outputs reach currents quickly from off
// - each grid lasts one step duration, then the next grid follows
// - after grid 63: mode 0 holds grid 63, mode 1 restarts at grid 0
// - output enable high or run enable clear stops at once; restart at 0
// - writes go to the configure side; avoid changing the executing side
// - execute side change applies only from grid 0 of next pass
// - step timing derived from the external clock input
// - stagger applies changes channel 0 to 23 with 50 ns spacing
// - stagger on run enable, grid steps, enable low; enable high all off
// - stagger disable bit set removes delay; resets to zero
// - output enable high puts all outputs high impedance, low enables all
// - reset clears all registers and serial state; channels deselected
// - reset pin must be held at least 2.5 us; ready within 1.5 ms
// - serial input sampled on clock rising edges only while select low
package lgs_pkg;
   localparam int NUM_CH   = 24;
   localparam int NUM_GRP  = 4;
   localparam int NUM_GRID = 64;
   localparam int CUR_W    = 6;
   localparam int GRID_W   = 6;
   localparam int SEL_W    = 2;
   localparam int DUR_W    = 16;
   localparam int ADDR_W   = 12;
   localparam int CH_W     = 5;

   localparam logic [ADDR_W-1:0] ADDR_CTRL      = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_DUR       = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_STAT      = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_CH_BASE   = 12'h100;
   localparam logic [ADDR_W-1:0] ADDR_GRID_BASE = 12'h200;

   localparam int CTRL_RUN_BIT  = 0;
   localparam int CTRL_MODE_BIT = 1;
   localparam int CTRL_EXE_BIT  = 2;
   localparam int CTRL_CFG_BIT  = 3;
   localparam int CTRL_STAG_BIT = 4;
   localparam int CTRL_W        = 5;

   localparam int CH_EN_BIT   = 0;
   localparam int CH_GRP_LSB  = 1;
   localparam int CH_CUR1_LSB = 8;
   localparam int CH_CUR2_LSB = 16;
   localparam int CH_CUR3_LSB = 24;

   localparam logic [SEL_W-1:0] SEL_OFF  = 2'h0;
   localparam logic [SEL_W-1:0] SEL_CUR1 = 2'h1;
   localparam logic [SEL_W-1:0] SEL_CUR2 = 2'h2;

   localparam int CLK_PERIOD_NS = 25;
   localparam int STAGGER_NS    = 50;
   localparam int STAGGER_CYC   = (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_MIN_NS  = 2500;
   localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int SPI_FRAME_BITS = 16;
   localparam int SPI_RW_BIT     = 8;
   localparam int SPI_ADDR_LSB   = 9;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_RUN  = 2'b01,
      SEQ_HOLD = 2'b10
   } lgs_state_t;
endpackage : lgs_pkg

//--- rtl/lgs_sequencer.sv
// led gradation sequencer: apb and serial registers, grid stepper, stagger
`timescale 1ns/100ps
module lgs_sequencer
   import lgs_pkg::*;
(
   // clock and reset
   input  wire logic                      clock_i,
   input  wire logic                      srst_i,
   // apb slave
   input  wire logic                      psel_i,
   input  wire logic                      penable_i,
   input  wire logic                      pwrite_i,
   input  wire logic [ADDR_W-1:0]         paddr_i,
   input  wire logic [31:0]               pwdata_i,
   output logic      [31:0]               prdata_o,
   output logic                           pready_o,
   output logic                           pslverr_o,
   // device pins
   input  wire logic                      oe_n_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      external_clock_in_i,
   input  wire logic                      spi_cs_n_i,
   input  wire logic                      spi_sclk_i,
   input  wire logic                      spi_sdi_i,
   // led outputs
   output logic      [NUM_CH-1:0]         led_on_o,
   output logic      [NUM_CH*CUR_W-1:0]   led_cur_o,
   output logic                           led_drive_o
);
   localparam int NPIN = 6;
   localparam int P_OE = 0, P_RST = 1, P_EXT = 2, P_CS = 3, P_SCK = 4, P_SDI = 5;

   // pin synchronisers; stage 1 feeds stage 2 only
   logic [NPIN-1:0] sync1_q, sync2_q, sync3_q;
   always_ff @(posedge clock_i) begin
      sync1_q <= {spi_sdi_i, spi_sclk_i, spi_cs_n_i, external_clock_in_i, rst_n_i, oe_n_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
   end
   wire oe_n     = sync2_q[P_OE];
   wire ext_rise = sync2_q[P_EXT] & ~sync3_q[P_EXT];
   wire sck_rise = sync2_q[P_SCK] & ~sync3_q[P_SCK];
   wire cs_rise  = sync2_q[P_CS] & ~sync3_q[P_CS];

   // reset pin is filtered: only a long enough low pulse resets
   logic [7:0] rlow_q, rlow_d;
   logic       hwrst_q, hwrst_d;
   always_comb begin
      rlow_d  = sync2_q[P_RST] ? 8'h00 : rlow_q;
      hwrst_d = 1'b0;
      if (!sync2_q[P_RST]) begin
         if (rlow_q >= 8'(RESET_MIN_CYC - 1)) begin
            hwrst_d = 1'b1;
         end else begin
            rlow_d = rlow_q + 8'h01;
         end
      end
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rlow_q  <= 8'h00;
         hwrst_q <= 1'b0;
      end else begin
         rlow_q  <= rlow_d;
         hwrst_q <= hwrst_d;
      end
   end
   wire rst = srst_i | hwrst_q;

   // serial write port: shift only on sclk rise while select low
   logic [SPI_FRAME_BITS-1:0] sh_q, sh_d;
   logic [4:0]                scnt_q, scnt_d;
   logic                      spi_wr;
   always_comb begin
      sh_d   = sh_q;
      scnt_d = scnt_q;
      spi_wr = 1'b0;
      if (sync2_q[P_CS]) begin
         scnt_d = 5'h00;
         spi_wr = cs_rise && scnt_q == 5'(SPI_FRAME_BITS) && !sh_q[SPI_RW_BIT];
      end else if (sck_rise) begin
         sh_d = {sh_q[SPI_FRAME_BITS-2:0], sync2_q[P_SDI]};
         if (scnt_q != 5'(SPI_FRAME_BITS)) begin
            scnt_d = scnt_q + 5'h01;
         end
      end
   end
   always_ff @(posedge clock_i) begin
      if (rst) begin
         sh_q   <= '0;
         scnt_q <= 5'h00;
      end else begin
         sh_q   <= sh_d;
         scnt_q <= scnt_d;
      end
   end

   // configuration storage, two sides
   logic [CTRL_W-1:0]   ctrl_q;
   logic [DUR_W-1:0]    dur_q  [2];
   logic [31:0]         chc_q  [2][NUM_CH];
   logic [NUM_GRP*SEL_W-1:0] grid_q [2][NUM_GRID];
   logic                side_q;
   logic [GRID_W-1:0]   gidx_q;
   lgs_state_t          st_q;

   wire cfg_side = ctrl_q[CTRL_CFG_BIT];

   // apb answers one cycle into the access phase
   logic [31:0] prdata_d;
   logic        pready_d, pslverr_d, hit;
   wire         apb_acc = psel_i & penable_i & ~pready_o;
   wire         apb_wr  = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
   wire [ADDR_W-1:0] ch_off   = paddr_i - ADDR_CH_BASE;
   wire [ADDR_W-1:0] grid_off = paddr_i - ADDR_GRID_BASE;

   always_comb begin
      prdata_d  = 32'h0;
      hit       = 1'b1;
      if (paddr_i[1:0] != 2'h0) begin
         hit = 1'b0;
      end else if (paddr_i == ADDR_CTRL) begin
         prdata_d = 32'(ctrl_q);
      end else if (paddr_i == ADDR_DUR) begin
         prdata_d = 32'(dur_q[cfg_side]);
      end else if (paddr_i == ADDR_STAT) begin
         prdata_d = {22'h0, side_q, st_q, 1'b0, gidx_q};
      end else if (paddr_i >= ADDR_CH_BASE && ch_off < ADDR_W'(NUM_CH * 4)) begin
         prdata_d = chc_q[cfg_side][ch_off[CH_W+1:2]];
      end else if (paddr_i >= ADDR_GRID_BASE && grid_off < ADDR_W'(NUM_GRID * 4)) begin
         prdata_d = 32'(grid_q[cfg_side][grid_off[GRID_W+1:2]]);
      end else begin
         hit = 1'b0;
      end
      pready_d  = apb_acc;
      pslverr_d = apb_acc & ~hit;
      if (!hit || pwrite_i) begin
         prdata_d = 32'h0;
      end
   end
   always_ff @(posedge clock_i) begin
      if (rst) begin
         prdata_o  <= 32'h0;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         prdata_o  <= prdata_d;
         pready_o  <= pready_d;
         pslverr_o <= pslverr_d;
      end
   end

   // shared write port; apb wins over a simultaneous serial frame
   logic [ADDR_W-1:0] wa;
   logic [31:0]       wd;
   logic              we, wlow;
   always_comb begin
      wa   = paddr_i;
      wd   = pwdata_i;
      we   = apb_wr;
      wlow = 1'b0;
      if (!apb_wr && spi_wr) begin
         wa   = {3'h0, sh_q[SPI_FRAME_BITS-1:SPI_ADDR_LSB], 2'h0};
         wd   = 32'(sh_q[7:0]);
         we   = 1'b1;
         wlow = 1'b1;
      end
   end
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic low);
      merge = low ? {old[31:8], nw[7:0]} : nw;
   endfunction : merge

   wire [ADDR_W-1:0] wch  = wa - ADDR_CH_BASE;
   wire [ADDR_W-1:0] wgr  = wa - ADDR_GRID_BASE;
   wire              w_ch = we && wa >= ADDR_CH_BASE && wch < ADDR_W'(NUM_CH * 4);
   wire              w_gr = we && wa >= ADDR_GRID_BASE && wgr < ADDR_W'(NUM_GRID * 4);
   localparam logic [31:0] CH_MASK = 32'h3f3f3f07;

   always_ff @(posedge clock_i) begin
      if (rst) begin
         ctrl_q <= '0;
         for (int s = 0; s < 2; s++) begin
            dur_q[s] <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
               chc_q[s][c] <= 32'h0;
            end
            for (int g = 0; g < NUM_GRID; g++) begin
               grid_q[s][g] <= '0;
            end
         end
      end else begin
         if (we && wa == ADDR_CTRL) begin
            ctrl_q <= CTRL_W'(merge(32'(ctrl_q), wd, wlow));
         end
         if (we && wa == ADDR_DUR) begin
            dur_q[cfg_side] <= DUR_W'(merge(32'(dur_q[cfg_side]), wd, wlow));
         end
         if (w_ch) begin
            chc_q[cfg_side][wch[CH_W+1:2]] <=
               merge(chc_q[cfg_side][wch[CH_W+1:2]], wd, wlow) & CH_MASK;
         end
         if (w_gr) begin
            grid_q[cfg_side][wgr[GRID_W+1:2]] <= wd[NUM_GRP*SEL_W-1:0];
         end
      end
   end

   // grid stepper
   lgs_state_t        st_d;
   logic              side_d, upd;
   logic [GRID_W-1:0] gidx_d;
   logic [DUR_W-1:0]  cnt_q, cnt_d;
   wire run_ok  = ~oe_n & ctrl_q[CTRL_RUN_BIT];
   wire new_sd  = ctrl_q[CTRL_EXE_BIT];
   always_comb begin
      st_d   = st_q;
      side_d = side_q;
      gidx_d = gidx_q;
      cnt_d  = cnt_q;
      upd    = 1'b0;
      case (st_q)
         SEQ_IDLE: begin
            if (run_ok) begin
               st_d   = SEQ_RUN;
               side_d = new_sd;
               gidx_d = '0;
               cnt_d  = dur_q[new_sd];
               upd    = 1'b1;
            end
         end
         SEQ_RUN: begin
            if (!run_ok) begin
               st_d   = SEQ_IDLE;
               gidx_d = '0;
               upd    = 1'b1;
            end else if (ext_rise) begin
               if (cnt_q > DUR_W'(1)) begin
                  cnt_d = cnt_q - DUR_W'(1);
               end else if (gidx_q != GRID_W'(NUM_GRID - 1)) begin
                  gidx_d = gidx_q + GRID_W'(1);
                  cnt_d  = dur_q[side_q];
                  upd    = 1'b1;
               end else if (ctrl_q[CTRL_MODE_BIT]) begin
                  gidx_d = '0;
                  side_d = new_sd;
                  cnt_d  = dur_q[new_sd];
                  upd    = 1'b1;
               end else begin
                  st_d = SEQ_HOLD;
               end
            end
         end
         SEQ_HOLD: begin
            if (!run_ok) begin
               st_d   = SEQ_IDLE;
               gidx_d = '0;
               upd    = 1'b1;
            end
         end
         default: begin
            st_d   = SEQ_IDLE;
            gidx_d = '0;
         end
      endcase
   end
   always_ff @(posedge clock_i) begin
      if (rst) begin
         st_q   <= SEQ_IDLE;
         side_q <= 1'b0;
         gidx_q <= '0;
         cnt_q  <= '0;
      end else begin
         st_q   <= st_d;
         side_q <= side_d;
         gidx_q <= gidx_d;
         cnt_q  <= cnt_d;
      end
   end

   // per-channel target from the executing side (uses next state so no lag)
   logic [NUM_CH-1:0]       tgt_on;
   logic [NUM_CH*CUR_W-1:0] tgt_cur;
   always_comb begin
      logic [31:0]              cfg;
      logic [SEL_W-1:0]         sel;
      logic [NUM_GRP*SEL_W-1:0] row;
      cfg = 32'h0;
      sel = SEL_OFF;
      row = grid_q[side_d][gidx_d];
      for (int c = 0; c < NUM_CH; c++) begin
         cfg = chc_q[side_d][c];
         sel = row[cfg[CH_GRP_LSB +: SEL_W] * SEL_W +: SEL_W];
         tgt_on[c] = st_d != SEQ_IDLE && cfg[CH_EN_BIT] && sel != SEL_OFF;
         case (sel)
            SEL_CUR1: tgt_cur[c*CUR_W +: CUR_W] = cfg[CH_CUR1_LSB +: CUR_W];
            SEL_CUR2: tgt_cur[c*CUR_W +: CUR_W] = cfg[CH_CUR2_LSB +: CUR_W];
            default:  tgt_cur[c*CUR_W +: CUR_W] = cfg[CH_CUR3_LSB +: CUR_W];
         endcase
         if (!tgt_on[c]) begin
            tgt_cur[c*CUR_W +: CUR_W] = '0;
         end
      end
   end

   // stagger: one channel per spacing, channel 0 first
   logic [CH_W-1:0]         ptr_q, ptr_d;
   logic [1:0]              tick_q, tick_d;
   logic                    busy_q, busy_d;
   logic [NUM_CH-1:0]       on_d;
   logic [NUM_CH*CUR_W-1:0] cur_d;
   always_comb begin
      ptr_d  = ptr_q;
      tick_d = tick_q;
      busy_d = busy_q;
      on_d   = led_on_o;
      cur_d  = led_cur_o;
      if (oe_n) begin
         // all channels off together, no stagger
         on_d   = '0;
         cur_d  = '0;
         busy_d = 1'b0;
      end else if (upd && ctrl_q[CTRL_STAG_BIT]) begin
         on_d   = tgt_on;
         cur_d  = tgt_cur;
         busy_d = 1'b0;
      end else begin
         if (upd) begin
            busy_d = 1'b1;
            ptr_d  = '0;
            tick_d = 2'h0;
         end
         if (upd || busy_q) begin
            if (upd || tick_q == 2'h0) begin
               on_d[ptr_d] = tgt_on[ptr_d];
               cur_d[ptr_d*CUR_W +: CUR_W] = tgt_cur[ptr_d*CUR_W +: CUR_W];
            end
            if (tick_d == 2'(STAGGER_CYC - 1)) begin
               tick_d = 2'h0;
               if (ptr_d == CH_W'(NUM_CH - 1)) begin
                  busy_d = 1'b0;
               end else begin
                  ptr_d = ptr_d + CH_W'(1);
               end
            end else begin
               tick_d = tick_d + 2'h1;
            end
         end
      end
   end
   always_ff @(posedge clock_i) begin
      if (rst) begin
         ptr_q       <= '0;
         tick_q      <= 2'h0;
         busy_q      <= 1'b0;
         led_on_o    <= '0;
         led_cur_o   <= '0;
         led_drive_o <= 1'b0;
      end else begin
         ptr_q       <= ptr_d;
         tick_q      <= tick_d;
         busy_q      <= busy_d;
         led_on_o    <= on_d;
         led_cur_o   <= cur_d;
         led_drive_o <= ~oe_n;
      end
   end
endmodule : lgs_sequencer

//--- dv/lgs_sequencer_chk.sv
// concurrent checks on the led gradation sequencer ports
`timescale 1ns/100ps
module lgs_sequencer_chk
   import lgs_pkg::*;
(
   // clock and reset
   input wire logic              clock_i,
   input wire logic              srst_i,
   // apb slave
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0]       prdata_o,
   input wire logic              pready_o,
   input wire logic              pslverr_o,
   // pins and leds
   input wire logic              oe_n_i,
   input wire logic [NUM_CH-1:0] led_on_o,
   input wire logic [NUM_CH*CUR_W-1:0] led_cur_o,
   input wire logic              led_drive_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);
   logic dark_clean;

   // a dark lane must not carry a stale preset code
   always_comb begin
      dark_clean = 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
         if (!led_on_o[c] && led_cur_o[CUR_W*c +: CUR_W] != '0) begin
            dark_clean = 1'b0;
         end
      end
   end

   a_ready_one_wait: assert property (
      (psel_i && !penable_i) ##1 (psel_i && penable_i) |-> !pready_o ##1 pready_o)
      else $error("apb answer not after one wait state");
   a_ready_single: assert property (pready_o |=> !pready_o)
      else $error("apb ready longer than one cycle");
   a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
      else $error("apb ready outside an access");
   a_misalign_err: assert property (pready_o && paddr_i[1:0] != 2'b00 |-> pslverr_o)
      else $error("misaligned access not refused");
   a_quiet_rdata: assert property (
      pready_o && (pwrite_i || pslverr_o) |-> prdata_o == '0)
      else $error("read data not zero on write or error");
   a_oe_high_dark: assert property (
      oe_n_i [*4] |-> !led_drive_o && led_on_o == '0 && led_cur_o == '0)
      else $error("outputs still driven with enable pin high");
   a_undriven_dark: assert property ($fell(led_drive_o) |-> led_on_o == '0)
      else $error("channels lit while outputs released");
   a_dark_no_code: assert property (dark_clean)
      else $error("unlit channel shows a current code");

   c_refused: cover property (pready_o && pslverr_o);
   c_all_lit: cover property (led_on_o == '1);
   c_release: cover property ($fell(led_drive_o));
endmodule : lgs_sequencer_chk

bind lgs_sequencer lgs_sequencer_chk i_lgs_sequencer_chk (
   .clock_i(clock_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .oe_n_i(oe_n_i), .led_on_o(led_on_o), .led_cur_o(led_cur_o),
   .led_drive_o(led_drive_o)
);

//--- dv/lgs_spi_master.sv
// serial write controller model driving select, clock and data pins
`timescale 1ns/100ps
module lgs_spi_master (
   // clock
   input  wire logic clock_i,
   // serial pins
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      sdi_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o  = 1'b1;
   end

   // levels held four fast clocks since the device only resamples the pins
   task automatic send(input logic [15:0] w, input int nbits);
      cs_n_o <= 1'b0;
      for (int i = nbits - 1; i >= 0; i--) begin
         sdi_o  <= w[i];
         repeat (4) @(posedge clock_i);
         sclk_o <= 1'b1; // data settled before the rise
         repeat (4) @(posedge clock_i);
         sclk_o <= 1'b0;
      end
      repeat (4) @(posedge clock_i);
      cs_n_o <= 1'b1; // idle with clock low
      sdi_o  <= ~w[0];
      repeat (6) @(posedge clock_i);
   endtask : send
endmodule : lgs_spi_master

//--- dv/tb.sv
// self-checking bench for the led gradation sequencer
`timescale 1ns/100ps
module tb;
   import lgs_pkg::*;
   localparam int LW = NUM_CH * (CUR_W + 1);
   logic              clock_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic              oe_n_i, rst_n_i, ext_clk, cs_n, sclk, sdi, led_drive_o, err;
   logic [ADDR_W-1:0] paddr_i;
   logic [31:0]       pwdata_i, prdata_o, rd;
   logic [NUM_CH-1:0] led_on_o, mask;
   logic [143:0]      led_cur_o;
   logic [31:0]       ch_cfg [NUM_CH];
   logic [7:0]        grid [NUM_GRID];
   integer            seed = 32'he67836cd;
   int                failures = 0;
   int                total_checks = 0;
   int                n;

   lgs_sequencer i_lgs_sequencer (
      .clock_i(clock_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .oe_n_i(oe_n_i), .rst_n_i(rst_n_i),
      .external_clock_in_i(ext_clk), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
      .spi_sdi_i(sdi), .led_on_o(led_on_o), .led_cur_o(led_cur_o), .led_drive_o(led_drive_o));
   lgs_spi_master i_lgs_spi_master (
      .clock_i(clock_i), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));

   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic chk_led(input string what, input logic [LW-1:0] exp);
      total_checks++;
      if ({led_on_o, led_cur_o} !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, {led_on_o, led_cur_o});
      end
   endtask : chk_led

   function automatic logic [LW-1:0] exp_led(input int g);
      logic [LW-1:0] v;
      logic [1:0]    s;
      v = '0;
      for (int c = 0; c < NUM_CH; c++) begin
         s = grid[g][2*ch_cfg[c][2:1] +: 2];
         if (ch_cfg[c][0] && s != SEL_OFF) begin
            v[144+c] = 1'b1;
            v[CUR_W*c +: CUR_W] = ch_cfg[c][8*s +: CUR_W];
         end
      end
      return v;
   endfunction : exp_led

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      n = 0;
      psel_i    <= 1'b1;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) failures++;
      rd        = prdata_o;
      err       = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask : apb

   // k timebase edges per call, slow enough for the pin synchroniser
   task automatic steps(input int k);
      repeat (k) begin
         ext_clk <= 1'b1;
         repeat (4) @(posedge clock_i);
         ext_clk <= 1'b0;
         repeat (6) @(posedge clock_i);
      end
   endtask : steps

   task automatic chk_stat(input logic [1:0] st, input logic [5:0] g);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk("state and grid", {24'h0, st, g}, {24'h0, rd[8:7], rd[5:0]});
   endtask : chk_stat

   task automatic wait_ch0(input logic v);
      n = 0;
      while (led_on_o[0] !== v && n < 30) begin
         @(posedge clock_i);
         n++;
      end
      if (n >= 30) failures++;
   endtask : wait_ch0

   task automatic give_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (20000) @(posedge clock_i);
      failures++;
      give_verdict();
   end

   initial begin
      {srst_i, oe_n_i, rst_n_i} = 3'b111;
      {psel_i, penable_i, pwrite_i, ext_clk} = 4'h0;
      paddr_i  = '0;
      pwdata_i = '0;
      repeat (10) @(posedge clock_i);
      srst_i <= 1'b0;
      @(posedge clock_i);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      apb(1'b0, ADDR_CH_BASE + 12'h05c, 32'h0);
      chk("channel reset", 32'h0, rd);
      apb(1'b0, 12'h00c, 32'h0);
      chk("unmapped refused", 32'h1, {31'h0, err});
      apb(1'b1, 12'h101, 32'hffffffff);
      chk("misaligned refused", 32'h1, {31'h0, err});
      for (int c = 0; c < NUM_CH; c++) begin
         ch_cfg[c] = $random(seed) & 32'h3f3f3f07;
         if (c < 2) ch_cfg[c][0] = c[0];
         apb(1'b1, ADDR_CH_BASE + ADDR_W'(4 * c), ch_cfg[c]);
      end
      // first grid carries all four selector codes
      for (int g = 0; g < NUM_GRID; g++) begin
         grid[g] = (g == 0) ? 8'he4 : 8'($random(seed));
         apb(1'b1, ADDR_GRID_BASE + ADDR_W'(4 * g), {24'h0, grid[g]});
      end
      apb(1'b0, ADDR_CH_BASE + 12'h01c, 32'h0);
      chk("channel readback", ch_cfg[7], rd);
      apb(1'b1, ADDR_DUR, 32'h2);
      apb(1'b1, ADDR_CTRL, 32'h10);
      oe_n_i <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h11);
      repeat (6) @(posedge clock_i);
      chk_led("grid 0", exp_led(0));
      steps(1);
      chk_led("grid 0 held", exp_led(0));
      steps(1);
      chk_led("grid 1", exp_led(1));
      steps(124);
      chk_led("grid 63", exp_led(63));
      steps(4);
      chk_stat(2'd2, 6'd63);
      apb(1'b1, ADDR_CTRL, 32'h10);
      repeat (4) @(posedge clock_i);
      chk_led("stopped", '0);
      chk_stat(2'd0, 6'd0);
      apb(1'b1, ADDR_CTRL, 32'h13);
      apb(1'b1, ADDR_CTRL, 32'h17);
      chk_stat(2'd1, 6'd0);
      chk("side held", 32'h0, {31'h0, rd[9]});
      steps(128);
      chk_stat(2'd1, 6'd0);
      chk("side switched", 32'h1, {31'h0, rd[9]});
      chk_led("blank side", '0);
      oe_n_i <= 1'b1;
      repeat (5) @(posedge clock_i);
      chk("drive released", 32'h0, {31'h0, led_drive_o});
      chk_stat(2'd0, 6'd0);
      for (int c = 0; c < NUM_CH; c++) begin
         apb(1'b1, ADDR_CH_BASE + ADDR_W'(4 * c), 32'h101);
      end
      apb(1'b1, ADDR_GRID_BASE, 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h1);
      oe_n_i <= 1'b0;
      wait_ch0(1'b1);
      for (int i = 0; i < 2 * NUM_CH; i++) begin
         mask = {NUM_CH{1'b1}} >> (NUM_CH - 1 - i / 2);
         chk("stagger mask", {8'h0, mask}, {8'h0, led_on_o});
         @(posedge clock_i);
      end
      oe_n_i <= 1'b1;
      wait_ch0(1'b0);
      chk("all off at once", 32'h0, {8'h0, led_on_o});
      apb(1'b1, ADDR_CTRL, 32'h0);
      i_lgs_spi_master.send(16'h025a, 16);
      i_lgs_spi_master.send(16'h03a5, 16);
      i_lgs_spi_master.send(16'h0233, 15);
      repeat (8) @(posedge clock_i);
      apb(1'b0, ADDR_DUR, 32'h0);
      chk("serial write", 32'h5a, rd);
      apb(1'b0, ADDR_CH_BASE + 12'h004, 32'h0);
      chk("short frame dropped", 32'h101, rd);
      apb(1'b1, ADDR_CTRL, 32'h1c);
      apb(1'b0, ADDR_DUR, 32'h0);
      chk("configure side dur", 32'h0, rd);
      rst_n_i <= 1'b0;
      repeat (RESET_MIN_CYC + 20) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (8) @(posedge clock_i);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl after pin reset", 32'h0, rd);
      give_verdict();
   end
endmodule : tb
